// [tb/fldc_mon_model.sv]
`timescale 1ns/100ps
`default_nettype none
// monitor side: one burst of readings per conversion
module fldc_mon_model (
	input  wire logic        clk,
	input  wire logic        fire,
	input  wire logic [7:0]  k,
	output var  logic        conv_done,
	output wire logic [15:0] vout0,
	output wire logic [15:0] vout1,
	output wire logic [15:0] iout0,
	output wire logic [15:0] iout1,
	output wire logic [15:0] vin,
	output wire logic [7:0]  status_vout0,
	output wire logic [7:0]  status_vout1,
	output wire logic [15:0] status_word0,
	output wire logic [15:0] status_word1,
	output wire logic [7:0]  status_mfr0,
	output wire logic [7:0]  status_mfr1
);
	logic [7:0] b [20];
	initial begin
		conv_done = 1'b0;
		foreach (b[j]) b[j] = 8'h00;
	end
	// churn outside the done cycle, so a stray sample shows
	always @(posedge clk) begin
		conv_done <= fire;
		foreach (b[j]) b[j] <= fire ? 8'((k << 5) + j) : ~b[j];
	end
	assign vout0 = {b[0], b[1]};
	assign vout1 = {b[2], b[3]};
	assign iout0 = {b[4], b[5]};
	assign iout1 = {b[6], b[7]};
	assign vin = {b[8], b[9]};
	assign status_vout0 = b[12];
	assign status_vout1 = b[13];
	assign status_word0 = {b[14], b[15]};
	assign status_word1 = {b[16], b[17]};
	assign status_mfr0 = b[18];
	assign status_mfr1 = b[19];
endmodule
`default_nettype wire

// [tb/fldc_props.sv]
`timescale 1ns/100ps
`default_nettype none
module fldc_props (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [7:0] addr,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata_reg,
	input wire logic       warn,
	input wire logic       alert_reg,
	input wire logic       run_pin,
	input wire logic       out_enable_reg,
	input wire logic       soft_off_reg,
	input wire logic       page_reg,
	input wire logic [6:0] bus_addr_reg,
	input wire logic       pec_req_reg,
	input wire logic       cfg_ready_reg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// longer than the run synchroniser plus output flop
	sequence run_low_s;
		!run_pin [*6];
	endsequence
	sequence idle_cfg_s;
		(cfg_ready_reg && !wr) [*3];
	endsequence
	chk_alert_copy: assert property (1 |=> alert_reg == $past(warn))
		else $error("alert not tracking warn");
	chk_rd_idle: assert property (!rd |=> rdata_reg == 8'h00)
		else $error("read data outside read slot");
	chk_count_val: assert property (rd && addr == 8'h14 |=> rdata_reg inside {8'd0, 8'd147})
		else $error("bad log count");
	chk_unmapped_zero: assert property (rd && addr == 8'h24 |=> rdata_reg == 8'h00)
		else $error("unmapped read not zero");
	chk_def_cfg: assert property ($rose(cfg_ready_reg) |-> ##[0:2]
		(bus_addr_reg == 7'h4f && !page_reg && !pec_req_reg)) else $error("defaults wrong");
	chk_cfg_steady: assert property (idle_cfg_s |=> $stable({page_reg, bus_addr_reg, pec_req_reg}))
		else $error("config moved without command");
	chk_run_off: assert property (run_low_s |-> !out_enable_reg)
		else $error("output on with run low");
	chk_enable_cfg: assert property (out_enable_reg |-> cfg_ready_reg)
		else $error("output on before config");
	chk_soft_pulse: assert property (soft_off_reg |=> !soft_off_reg)
		else $error("soft off not a pulse");
endmodule
bind fldc_top fldc_props fldc_props_inst (.clk(clk), .nrst(nrst), .addr(addr), .wr(wr), .rd(rd),
	.rdata_reg(rdata_reg), .warn(warn), .alert_reg(alert_reg), .run_pin(run_pin),
	.out_enable_reg(out_enable_reg), .soft_off_reg(soft_off_reg), .page_reg(page_reg),
	.bus_addr_reg(bus_addr_reg), .pec_req_reg(pec_req_reg), .cfg_ready_reg(cfg_ready_reg));
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        fire = 1'b0;
	logic [7:0]  k = 8'h00;
	logic [7:0]  fault_ch0 = 8'h00;
	logic [7:0]  fault_ch1 = 8'h00;
	logic        warn = 1'b0;
	logic        run_pin = 1'b0;
	wire  [7:0]  rdata_reg, status_vout0, status_vout1, status_mfr0, status_mfr1;
	wire         irq_reg, alert_reg, out_enable_reg, soft_off_reg, page_reg, pec_req_reg, cfg_ready_reg;
	wire         conv_done;
	wire  [6:0]  bus_addr_reg;
	wire  [15:0] vout0, vout1, iout0, iout1, vin, status_word0, status_word1;
	int          n_errors = 0;
	int          comparisons = 0;
	logic [7:0]  d;
	logic [7:0]  exp_b;
	logic [7:0]  codes [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0a,
		8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h1a, 8'hff};
	logic [7:0]  defs [4] = '{8'h00, 8'h4f, 8'h00, 8'h80};

	always #20 clk = ~clk;

	fldc_top fldc_top_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_reg(rdata_reg), .irq_reg(irq_reg), .conv_done(conv_done), .vout0(vout0), .vout1(vout1),
		.iout0(iout0), .iout1(iout1), .vin(vin), .status_vout0(status_vout0), .status_vout1(status_vout1),
		.status_word0(status_word0), .status_word1(status_word1), .status_mfr0(status_mfr0),
		.status_mfr1(status_mfr1), .fault_ch0(fault_ch0), .fault_ch1(fault_ch1), .warn(warn),
		.run_pin(run_pin), .alert_reg(alert_reg), .out_enable_reg(out_enable_reg),
		.soft_off_reg(soft_off_reg), .page_reg(page_reg), .bus_addr_reg(bus_addr_reg),
		.pec_req_reg(pec_req_reg), .cfg_ready_reg(cfg_ready_reg));

	fldc_mon_model fldc_mon_model_inst (.clk(clk), .fire(fire), .k(k), .conv_done(conv_done),
		.vout0(vout0), .vout1(vout1), .iout0(iout0), .iout1(iout1), .vin(vin),
		.status_vout0(status_vout0), .status_vout1(status_vout1), .status_word0(status_word0),
		.status_word1(status_word1), .status_mfr0(status_mfr0), .status_mfr1(status_mfr1));

	////////////////////////////////////////////////////////////////////////////////
	task wr_reg(input [7:0] a, input [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input [7:0] a, output [7:0] q);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata_reg;
	endtask
	task chk(input [7:0] got, input [7:0] want);
		comparisons++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task conv(input [7:0] kk);
		@(posedge clk);
		k <= kk;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task finish_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200us;
		n_errors++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		for (int n = 0; n < 20 && cfg_ready_reg !== 1'b1; n++) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h18, 8'(i));
			rd_reg(8'h1c, d);
			chk(d, defs[i]);
		end
		chk({1'b0, bus_addr_reg}, 8'h4f);
		chk({6'h0, page_reg, pec_req_reg}, 8'h00);
		$display("test defaults done");
		for (int i = 0; i < 17; i++) begin
			wr_reg(8'h00, 8'h04);
			if (i == 0) begin
				rd_reg(8'h14, d);
				chk(d, 8'h00);
				@(posedge clk);
			end
			if (i == 16) wr_reg(8'h00, 8'h01);
			else begin
				{fault_ch1, fault_ch0} <= 16'h0001 << i;
				@(posedge clk);
				{fault_ch1, fault_ch0} <= 16'h0000;
			end
			conv(8'h01);
			wr_reg(8'h0c, 8'h04);
			rd_reg(8'h10, d);
			chk(d, codes[i]);
		end
		chk({7'h0, irq_reg}, 8'h00);
		$display("test causes done");
		wr_reg(8'h00, 8'h04);
		wr_reg(8'h04, 8'h07);
		wr_reg(8'h08, 8'h01);
		for (int c = 1; c < 6; c++) conv(8'(c));
		fault_ch1 <= 8'h08;
		@(posedge clk);
		fault_ch1 <= 8'h00;
		conv(8'h06);
		#1;
		chk({7'h0, irq_reg}, 8'h01);
		rd_reg(8'h14, d);
		chk(d, 8'd147);
		wr_reg(8'h0c, 8'h04);
		rd_reg(8'h10, d);
		chk(d, 8'h13);
		wr_reg(8'h0c, 8'd27);
		for (int r = 0; r < 6; r++) begin
			for (int j = 0; j < 20; j++) begin
				exp_b = (j == 10 || j == 11) ? 8'h00 : 8'(((6 - r) << 5) + j);
				rd_reg(8'h10, d);
				chk(d, exp_b);
			end
		end
		wr_reg(8'h04, 8'h01);
		repeat (2) @(posedge clk);
		chk({7'h0, irq_reg}, 8'h00);
		$display("test record done");
		warn <= 1'b1;
		@(posedge clk);
		warn <= 1'b0;
		rd_reg(8'h04, d);
		chk(d & 8'h02, 8'h02);
		rd_reg(8'h24, d);
		chk(d, 8'h00);
		@(posedge clk);
		run_pin <= 1'b1;
		repeat (8) @(posedge clk);
		chk({7'h0, out_enable_reg}, 8'h01);
		run_pin <= 1'b0;
		d = 8'h00;
		for (int n = 0; n < 10; n++) begin
			@(posedge clk);
			#1 if (soft_off_reg === 1'b1) d = 8'h01;
		end
		chk(d, 8'h01);
		chk({7'h0, out_enable_reg}, 8'h00);
		$display("test run done");
		wr_reg(8'h18, 8'h01);
		wr_reg(8'h1c, 8'h21);
		repeat (2) @(posedge clk);
		chk({1'b0, bus_addr_reg}, 8'h21);
		wr_reg(8'h00, 8'h02);
		repeat (8) @(posedge clk);
		rd_reg(8'h04, d);
		chk(d & 8'h04, 8'h04);
		rd_reg(8'h1c, d);
		chk(d, 8'h21);
		$display("test store done");
		finish_test();
	end
endmodule
`default_nettype wire

// [verilog/fldc_cfg.v]
`timescale 1ns/100ps
`default_nettype none
`include "fldc_defines.vh"

module fldc_cfg (
	input  wire        clk,
	input  wire        nrst,
	input  wire        store_all,
	input  wire        wr_en,
	input  wire [1:0]  wr_idx,
	input  wire [7:0]  wr_data,
	output wire [31:0] ram_flat,
	output reg         ready_reg,
	output reg         busy_reg,
	output reg         store_done_reg
);

	localparam ST_LOAD  = 2'd0;
	localparam ST_IDLE  = 2'd1;
	localparam ST_STORE = 2'd2;

	reg [7:0] nvm_mem [0:3];
	reg [7:0] ram_mem [0:3];
	reg [1:0] state_reg;
	reg [1:0] idx_reg;
	integer   i;

	assign ram_flat = {ram_mem[3], ram_mem[2], ram_mem[1], ram_mem[0]};

	////////////////////////////////////////////////////////////////////////
	// nonvolatile image holds the factory defaults until a store-all
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nvm_mem[0] <= `FLDC_DEF_PAGE;
			nvm_mem[1] <= `FLDC_DEF_ADDR;
			nvm_mem[2] <= `FLDC_DEF_PEC;
			nvm_mem[3] <= `FLDC_DEF_OPER;
			for (i = 0; i < 4; i = i + 1) begin
				ram_mem[i] <= 8'h00;
			end
			state_reg      <= ST_LOAD;
			idx_reg        <= 2'd0;
			ready_reg      <= 1'b0;
			busy_reg       <= 1'b1;
			store_done_reg <= 1'b0;
		end else begin
			store_done_reg <= 1'b0;
			case (state_reg)
			ST_LOAD: begin
				ram_mem[idx_reg] <= nvm_mem[idx_reg];
				idx_reg <= idx_reg + 2'd1;
				if (idx_reg == `FLDC_CFG_LAST) begin
					state_reg <= ST_IDLE;
					ready_reg <= 1'b1;
					busy_reg  <= 1'b0;
				end
			end
			ST_IDLE: begin
				// host writes land only in working ram
				if (wr_en) begin
					ram_mem[wr_idx] <= wr_data;
				end
				if (store_all) begin
					state_reg <= ST_STORE;
					busy_reg  <= 1'b1;
					idx_reg   <= 2'd0;
				end
			end
			ST_STORE: begin
				nvm_mem[idx_reg] <= ram_mem[idx_reg];
				idx_reg <= idx_reg + 2'd1;
				if (idx_reg == `FLDC_CFG_LAST) begin
					state_reg      <= ST_IDLE;
					busy_reg       <= 1'b0;
					store_done_reg <= 1'b1;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// [verilog/fldc_defines.vh]
`ifndef FLDC_DEFINES_VH
`define FLDC_DEFINES_VH

// register byte addresses
`define FLDC_ADDR_CTRL      8'h00
`define FLDC_ADDR_STATUS    8'h04
`define FLDC_ADDR_MASK      8'h08
`define FLDC_ADDR_LOG_INDEX 8'h0c
`define FLDC_ADDR_LOG_DATA  8'h10
`define FLDC_ADDR_LOG_COUNT 8'h14
`define FLDC_ADDR_CFG_INDEX 8'h18
`define FLDC_ADDR_CFG_DATA  8'h1c
`define FLDC_ADDR_STATE     8'h20

// control register bits (write-only pulses)
`define FLDC_CTRL_FORCE_STORE 0
`define FLDC_CTRL_STORE_ALL   1
`define FLDC_CTRL_CLEAR_LOG   2

// status / mask bits
`define FLDC_ST_LOG_MADE   0
`define FLDC_ST_WARN       1
`define FLDC_ST_STORE_DONE 2
`define FLDC_ST_WIDTH      3
`define FLDC_MASK_RESET    3'h0

// fault cause codes, channel 0, plus channel 1 offset and forced store
`define FLDC_CAUSE_ON_TIME  8'h00
`define FLDC_CAUSE_OUT_OV   8'h01
`define FLDC_CAUSE_OUT_UV   8'h02
`define FLDC_CAUSE_OUT_OC   8'h03
`define FLDC_CAUSE_OVER_T   8'h05
`define FLDC_CAUSE_UNDER_T  8'h06
`define FLDC_CAUSE_IN_UV    8'h07
`define FLDC_CAUSE_INT_T    8'h0a
`define FLDC_CAUSE_CH1_ADD  8'h10
`define FLDC_CAUSE_FORCED   8'hff

// log layout
`define FLDC_LOG_LEN        8'd147
`define FLDC_LOG_LAST       8'd146
`define FLDC_LOG_CAUSE_BYTE 8'd4
`define FLDC_LOG_REC_START  8'd27
`define FLDC_REC_BYTES      8'd20
`define FLDC_REC_COUNT      4'd6
`define FLDC_REC_NEWEST_OFS 4'd5
`define FLDC_PREFACE        32'h5a5a0101

// configuration words
`define FLDC_CFG_PAGE 2'd0
`define FLDC_CFG_ADDR 2'd1
`define FLDC_CFG_PEC  2'd2
`define FLDC_CFG_OPER 2'd3
`define FLDC_CFG_LAST 2'd3
`define FLDC_DEF_PAGE 8'h00
`define FLDC_DEF_ADDR 8'h4f
`define FLDC_DEF_PEC  8'h00
`define FLDC_DEF_OPER 8'h80
`define FLDC_OPER_ON_BIT 7

`endif

// [verilog/fldc_top.v]
`timescale 1ns/100ps
`default_nettype none
`include "fldc_defines.vh"

// Operation
// - channel 0 cause codes 0x00 to 0x0a
// - channel 1 adds 0x10, forced store 0xff
// - record bytes 0-9 readings, high first, bytes 10-11 zero
// - record bytes 12-19 status bytes and words
// - init copies nonvolatile config into ram
// - loaded config rules until first command
// - store-all writes ram back to nonvolatile
// - alert follows warnings without bus traffic
// - default page 0, address 0x4f, no pec
// - output on under run, soft off
// - log read 147 bytes, count zero if none
// - cause at byte 4, six records newest first
module fldc_top (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata_reg,
	output reg         irq_reg,
	input  wire        conv_done,
	input  wire [15:0] vout0,
	input  wire [15:0] vout1,
	input  wire [15:0] iout0,
	input  wire [15:0] iout1,
	input  wire [15:0] vin,
	input  wire [7:0]  status_vout0,
	input  wire [7:0]  status_vout1,
	input  wire [15:0] status_word0,
	input  wire [15:0] status_word1,
	input  wire [7:0]  status_mfr0,
	input  wire [7:0]  status_mfr1,
	input  wire [7:0]  fault_ch0,
	input  wire [7:0]  fault_ch1,
	input  wire        warn,
	input  wire        run_pin,
	output reg         alert_reg,
	output reg         out_enable_reg,
	output reg         soft_off_reg,
	output reg         page_reg,
	output reg  [6:0]  bus_addr_reg,
	output reg         pec_req_reg,
	output reg         cfg_ready_reg
);

	////////////////////////////////////////////////////////////////////////
	// cause encoder: lowest flag of channel 0 wins, then channel 1
	function [7:0] fldc_cause;
		input [7:0] flags;
		begin
			if (flags[0])
				fldc_cause = `FLDC_CAUSE_ON_TIME;
			else if (flags[1])
				fldc_cause = `FLDC_CAUSE_OUT_OV;
			else if (flags[2])
				fldc_cause = `FLDC_CAUSE_OUT_UV;
			else if (flags[3])
				fldc_cause = `FLDC_CAUSE_OUT_OC;
			else if (flags[4])
				fldc_cause = `FLDC_CAUSE_OVER_T;
			else if (flags[5])
				fldc_cause = `FLDC_CAUSE_UNDER_T;
			else if (flags[6])
				fldc_cause = `FLDC_CAUSE_IN_UV;
			else
				fldc_cause = `FLDC_CAUSE_INT_T;
		end
	endfunction

	reg  [159:0]            rec_mem [0:5];
	reg  [2:0]              wp_reg;
	reg                     log_valid_reg;
	reg                     pending_reg;
	reg  [7:0]              cause_reg;
	reg  [7:0]              log_idx_reg;
	reg  [1:0]              cfg_idx_reg;
	reg  [`FLDC_ST_WIDTH-1:0] status_reg;
	reg  [`FLDC_ST_WIDTH-1:0] mask_reg;
	reg                     run_s1_reg;
	reg                     run_s2_reg;
	reg                     run_s3_reg;
	reg                     run_level_reg;
	reg                     host_seen_reg;
	reg  [7:0]              rd_next;
	reg  [7:0]              log_byte;
	reg  [7:0]              rel;
	reg  [7:0]              rsel;
	reg  [7:0]              roff;
	reg  [3:0]              ring_t;
	reg  [3:0]              ring_idx;
	reg  [159:0]            rec_shift;
	wire [31:0]             ram_flat;
	wire [31:0]             preface = `FLDC_PREFACE;
	wire                    cfg_ready;
	wire                    cfg_busy;
	wire                    store_done;
	wire [159:0]            snapshot;
	wire                    ctrl_wr;
	wire                    force_store;
	wire                    store_all;
	wire                    clear_log;
	wire                    oper_on;
	wire [`FLDC_ST_WIDTH-1:0] st_set;
	wire [`FLDC_ST_WIDTH-1:0] st_clr;
	integer                 i;

	assign ctrl_wr     = wr && (addr == `FLDC_ADDR_CTRL);
	assign force_store = ctrl_wr && wdata[`FLDC_CTRL_FORCE_STORE];
	assign store_all   = ctrl_wr && wdata[`FLDC_CTRL_STORE_ALL];
	assign clear_log   = ctrl_wr && wdata[`FLDC_CTRL_CLEAR_LOG];
	assign oper_on     = ram_flat[8*`FLDC_CFG_OPER + `FLDC_OPER_ON_BIT];

	// byte 0 of the record is the top byte of the word
	assign snapshot = {vout0, vout1, iout0, iout1, vin, 16'h0000,
		status_vout0, status_vout1, status_word0, status_word1,
		status_mfr0, status_mfr1};

	fldc_cfg u_cfg (
		.clk            (clk),
		.nrst           (nrst),
		.store_all      (store_all),
		.wr_en          (wr && (addr == `FLDC_ADDR_CFG_DATA)),
		.wr_idx         (cfg_idx_reg),
		.wr_data        (wdata),
		.ram_flat       (ram_flat),
		.ready_reg      (cfg_ready),
		.busy_reg       (cfg_busy),
		.store_done_reg (store_done)
	);

	////////////////////////////////////////////////////////////////////////
	// record ring and capture
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < 6; i = i + 1) begin
				rec_mem[i] <= 160'h0;
			end
			wp_reg        <= 3'd0;
			log_valid_reg <= 1'b0;
			pending_reg   <= 1'b0;
			cause_reg     <= 8'h00;
		end else begin
			// a finishing capture beats a clear; a valid log blocks more logging
			if (clear_log && !(pending_reg && conv_done)) begin
				log_valid_reg <= 1'b0;
				pending_reg   <= 1'b0;
			end else if (!log_valid_reg) begin
				if (conv_done) begin
					rec_mem[wp_reg] <= snapshot;
					wp_reg <= (wp_reg == 3'd5) ? 3'd0 : wp_reg + 3'd1;
					if (pending_reg) begin
						log_valid_reg <= 1'b1;
						pending_reg   <= 1'b0;
					end
				end
				if (!pending_reg && cfg_ready) begin
					if (force_store) begin
						pending_reg <= 1'b1;
						cause_reg   <= `FLDC_CAUSE_FORCED;
					end else if (|fault_ch0) begin
						pending_reg <= 1'b1;
						cause_reg   <= fldc_cause(fault_ch0);
					end else if (|fault_ch1) begin
						pending_reg <= 1'b1;
						cause_reg   <= fldc_cause(fault_ch1) + `FLDC_CAUSE_CH1_ADD;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// log byte lookup, newest record first after the header
	always @* begin
		rel       = log_idx_reg - `FLDC_LOG_REC_START;
		rsel      = rel / `FLDC_REC_BYTES;
		roff      = rel - rsel * `FLDC_REC_BYTES;
		ring_t    = {1'b0, wp_reg} + `FLDC_REC_NEWEST_OFS - rsel[3:0];
		ring_idx  = (ring_t >= `FLDC_REC_COUNT) ? ring_t - `FLDC_REC_COUNT : ring_t;
		rec_shift = rec_mem[ring_idx[2:0]] << {roff, 3'b000};
		if (!log_valid_reg)
			log_byte = 8'h00;
		else if (log_idx_reg < 8'd4)
			log_byte = preface[{~log_idx_reg[1:0], 3'b000} +: 8];
		else if (log_idx_reg == `FLDC_LOG_CAUSE_BYTE)
			log_byte = cause_reg;
		else if (log_idx_reg < `FLDC_LOG_REC_START)
			log_byte = 8'h00;
		else
			log_byte = rec_shift[159:152];
	end

	////////////////////////////////////////////////////////////////////////
	// register read mux
	always @* begin
		rd_next = 8'h00;
		if (addr == `FLDC_ADDR_STATUS)
			rd_next = {5'h00, status_reg};
		else if (addr == `FLDC_ADDR_MASK)
			rd_next = {5'h00, mask_reg};
		else if (addr == `FLDC_ADDR_LOG_INDEX)
			rd_next = log_idx_reg;
		else if (addr == `FLDC_ADDR_LOG_DATA)
			rd_next = log_byte;
		else if (addr == `FLDC_ADDR_LOG_COUNT)
			rd_next = log_valid_reg ? `FLDC_LOG_LEN : 8'h00;
		else if (addr == `FLDC_ADDR_CFG_INDEX)
			rd_next = {6'h00, cfg_idx_reg};
		else if (addr == `FLDC_ADDR_CFG_DATA)
			rd_next = ram_flat[{cfg_idx_reg, 3'b000} +: 8];
		else if (addr == `FLDC_ADDR_STATE)
			rd_next = {1'b0, host_seen_reg, cfg_busy, out_enable_reg, run_level_reg, pending_reg,
				log_valid_reg, cfg_ready};
	end

	assign st_set = {store_done, warn, conv_done & pending_reg & ~log_valid_reg};
	assign st_clr = (wr && (addr == `FLDC_ADDR_STATUS)) ? wdata[`FLDC_ST_WIDTH-1:0] : 3'h0;

	////////////////////////////////////////////////////////////////////////
	// register file
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg     <= 8'h00;
			status_reg    <= 3'h0;
			mask_reg      <= `FLDC_MASK_RESET;
			log_idx_reg   <= 8'h00;
			cfg_idx_reg   <= 2'd0;
			irq_reg       <= 1'b0;
			host_seen_reg <= 1'b0;
		end else begin
			rdata_reg <= rd ? rd_next : 8'h00;
			// set beats clear in the same cycle
			status_reg <= (status_reg & ~st_clr) | st_set;
			irq_reg <= |(status_reg & mask_reg);
			if (wr || rd)
				host_seen_reg <= 1'b1;
			if (wr && (addr == `FLDC_ADDR_MASK))
				mask_reg <= wdata[`FLDC_ST_WIDTH-1:0];
			if (wr && (addr == `FLDC_ADDR_CFG_INDEX))
				cfg_idx_reg <= wdata[1:0];
			if (wr && (addr == `FLDC_ADDR_LOG_INDEX))
				log_idx_reg <= (wdata > `FLDC_LOG_LAST) ? `FLDC_LOG_LAST : wdata;
			else if (rd && (addr == `FLDC_ADDR_LOG_DATA) && (log_idx_reg != `FLDC_LOG_LAST))
				log_idx_reg <= log_idx_reg + 8'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run pin synchroniser, change taken once stages two and three agree
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_s1_reg    <= 1'b0;
			run_s2_reg    <= 1'b0;
			run_s3_reg    <= 1'b0;
			run_level_reg <= 1'b0;
		end else begin
			run_s1_reg <= run_pin;
			run_s2_reg <= run_s1_reg;
			run_s3_reg <= run_s2_reg;
			if (run_s2_reg == run_s3_reg)
				run_level_reg <= run_s3_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// active configuration outputs; held off until ram is loaded, except alert, which follows warn from reset
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alert_reg      <= 1'b0;
			out_enable_reg <= 1'b0;
			soft_off_reg   <= 1'b0;
			page_reg       <= 1'b0;
			bus_addr_reg   <= 7'h00;
			pec_req_reg    <= 1'b0;
			cfg_ready_reg  <= 1'b0;
		end else begin
			alert_reg     <= warn;
			cfg_ready_reg <= cfg_ready;
			if (cfg_ready) begin
				// ram still mirrors the loaded image until the host writes
				page_reg       <= ram_flat[8*`FLDC_CFG_PAGE];
				bus_addr_reg   <= ram_flat[8*`FLDC_CFG_ADDR +: 7];
				pec_req_reg    <= ram_flat[8*`FLDC_CFG_PEC];
				out_enable_reg <= oper_on & run_level_reg;
				soft_off_reg   <= oper_on & out_enable_reg & ~run_level_reg;
			end else begin
				out_enable_reg <= 1'b0;
				soft_off_reg   <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire
